// File: shared/asc_pkg.sv
// package: register map, field layout, reset values and timing for the converter control
package asc_pkg;
   // ----------------------------------------------------------------
   // register map (printed offsets are not multiples of four: indices)
   // ----------------------------------------------------------------
   localparam logic [7:0] ASC_IDX_CTRL_ONE = 8'hB4;
   localparam logic [7:0] ASC_IDX_CTRL_TWO = 8'hB5;
   localparam logic [7:0] ASC_IDX_RES_HIGH = 8'hBB;
   localparam logic [7:0] ASC_IDX_RES_LOW  = 8'hBA;
   localparam int         ASC_ADDR_W       = 10;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int ASC_DONE_BIT  = 7;
   localparam int ASC_START_BIT = 6;
   localparam int ASC_SRC_LSB   = 4;
   localparam int ASC_RND_LSB   = 2;
   localparam int ASC_REF_LSB   = 6;
   localparam int ASC_DEC_LSB   = 4;
   localparam int ASC_CH_LSB    = 0;
   // ----------------------------------------------------------------
   // codes and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] ASC_SRC_PIN   = 2'h0;
   localparam logic [1:0] ASC_SRC_FULL  = 2'h1;
   localparam logic [1:0] ASC_SRC_TIMER = 2'h2;
   localparam logic [1:0] ASC_SRC_SW    = 2'h3;
   localparam logic [1:0] ASC_RND_IDLE  = 2'h0;
   localparam logic [1:0] ASC_RND_STEP  = 2'h1;
   localparam logic [1:0] ASC_RSV_RST   = 2'h3;
   localparam logic [1:0] ASC_REF_RST   = 2'h0;
   localparam logic [1:0] ASC_DEC_RST   = 2'h1;
   localparam logic [3:0] ASC_CH_RST    = 4'h0;
   localparam logic [3:0] ASC_CH_SINGLE = 4'hC;
   localparam logic [7:0] ASC_RES_RST   = 8'h00;
   localparam logic [15:0] ASC_RANDOM_SHIFT_REGISTER_RST = 16'hFFFF; // all zero would lock
   localparam logic [15:0] ASC_RANDOM_SHIFT_REGISTER_POLY = 16'h8005;
   localparam int         ASC_RANDOM_SHIFT_REGISTER_STEPS = 13;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int         ASC_CLK_DIV    = 6;
   localparam logic [9:0] ASC_SETTLE_CYC = 10'd16;
   localparam logic [9:0] ASC_DEC_64     = 10'd64;
endpackage : asc_pkg

// File: shared/asc_conv_if.sv
// interface: between the sequencer and its converter clock divider
`timescale 1ns/10ps
interface asc_conv_if;
   logic tick; // one-cycle converter clock enable
   logic run;  // divider runs while high
   modport seq (input tick, output run);
   modport div (output tick, input run);
endinterface : asc_conv_if

// File: rtl/asc_clk_div.sv
// converter clock enable divider
`timescale 1ns/10ps
module asc_clk_div
   import asc_pkg::*;
#(
   parameter int DIV = ASC_CLK_DIV
)(
   input  wire logic clk,   // system clock
   input  wire logic rst_n, // synchronised reset, active low
   asc_conv_if.div   cv     // tick out, run in
);
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic       tick_q;
   logic       tick_d;

   always_comb
   begin
      cnt_d  = cnt_q;
      tick_d = 1'b0;
      if (!cv.run)
      begin
         cnt_d = 4'h0;
      end
      else if (cnt_q == 4'(DIV - 1))
      begin
         cnt_d  = 4'h0;
         tick_d = 1'b1;
      end
      else
      begin
         cnt_d = cnt_q + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q  <= 4'h0;
         tick_q <= 1'b0;
      end
      else
      begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign cv.tick = tick_q;
endmodule : asc_clk_div

// File: rtl/asc_ctrl.sv
// converter sequence control registers and sequencer
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
module asc_ctrl
   import asc_pkg::*;
(
   input  wire logic        ref_clk,          // 20 MHz system clock
   input  wire logic        rst_b,            // async reset, active low
   input  wire logic [9:0]  avs_address,      // byte address
   input  wire logic        avs_read,         // read request
   input  wire logic        avs_write,        // write request
   input  wire logic [31:0] avs_writedata,    // write data
   input  wire logic [3:0]  avs_byteenable,   // byte lanes
   output logic      [31:0] avs_readdata,     // read data
   output logic             avs_waitrequest,  // stall
   input  wire logic        external_trigger_pin, // trigger pin, async
   input  wire logic        timer_compare,    // timer channel 0 event
   input  wire logic [11:0] modulator_result, // filtered result
   output logic [3:0]       mux_channel,      // input being converted
   output logic [1:0]       reference_select, // reference for sequence
   output logic             converting,       // sequence running
   output logic             conversion_done_pulse, // sample ready
   output logic             irq               // interrupt, never raised
);
   // ----------------------------------------------------------------
   // reset release and pin synchroniser
   // ----------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic       rst_n;
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_sync_q <= 2'h0;
      end
      else
      begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   logic [2:0] pin_q;
   logic       pin_lvl_q;
   logic       pin_lvl_d;
   always_comb
   begin
      pin_lvl_d = pin_lvl_q;
      if (pin_q[1] == pin_q[2])
      begin
         pin_lvl_d = pin_q[2];
      end
   end
   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function automatic logic [15:0] random_shift_register_step(input logic [15:0] v);
      logic [15:0] r;
      r = v;
      for (int i = 0; i < ASC_RANDOM_SHIFT_REGISTER_STEPS; i++)
      begin
         r = {r[14:0], 1'b0} ^ (r[15] ? ASC_RANDOM_SHIFT_REGISTER_POLY : 16'h0000);
      end
      return r;
   endfunction : random_shift_register_step

   function automatic logic [11:0] res_mask(input logic [1:0] dec);
      case (dec)
         2'h0:    res_mask = 12'hFE0; // 7 bits
         2'h1:    res_mask = 12'hFF8; // 9 bits
         2'h2:    res_mask = 12'hFFC; // 10 bits
         default: res_mask = 12'hFFF; // 12 bits
      endcase
   endfunction : res_mask
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ASC_IDLE, ASC_SETTLE, ASC_CONV} asc_state_t;
   asc_state_t  st_q, st_d;
   logic        done_q, done_d;
   logic        start_q, start_d;
   logic [1:0]  src_q, src_d;
   logic [1:0]  rnd_q, rnd_d;
   logic [1:0]  rsv_q, rsv_d;
   logic [1:0]  ref_q, ref_d;
   logic [1:0]  dec_q, dec_d;
   logic [3:0]  endch_q, endch_d;   // programmed end channel
   logic [3:0]  lastch_q, lastch_d; // read-back of last conversion
   logic [3:0]  cur_q, cur_d;
   logic [9:0]  cnt_q, cnt_d;
   logic [11:0] res_q, res_d;
   logic [15:0] random_shift_register_q, random_shift_register_d;
   logic        wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic        pulse_q, pulse_d;
   logic        trig_d;
   logic        conv_q, conv_d;
   logic        irq_q, irq_d;

   asc_conv_if cv ();
   asc_clk_div #(.DIV(ASC_CLK_DIV)) u_div (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .cv    (cv)
   );
   assign cv.run = (st_q != ASC_IDLE);

   logic       acc;
   logic       hit1, hit2, hitr, hitl;
   logic [7:0] idx;
   logic       pin_rise;
   assign acc  = (avs_read || avs_write) && wait_q;
   assign idx  = avs_address[9:2];
   assign hit1 = (idx == ASC_IDX_CTRL_ONE);
   assign hit2 = (idx == ASC_IDX_CTRL_TWO);
   assign hitr = (idx == ASC_IDX_RES_HIGH);
   assign hitl = (idx == ASC_IDX_RES_LOW);
   assign pin_rise = pin_lvl_d && !pin_lvl_q;
   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;  done_d = done_q;  start_d = start_q;
      src_d = src_q;  rnd_d = rnd_q;  rsv_d = rsv_q;
      ref_d = ref_q;  dec_d = dec_q;  endch_d = endch_q;
      lastch_d = lastch_q;  cur_d = cur_q;  cnt_d = cnt_q;
      res_d = res_q;  random_shift_register_d = random_shift_register_q;  pulse_d = 1'b0;
      rdata_d = rdata_q;
      // one wait cycle per access, answer on the second edge
      wait_d = !acc;
      trig_d = 1'b0;
      // only extra conversions interrupt, and they live elsewhere
      irq_d  = 1'b0;

      if (rnd_q == ASC_RND_STEP)
      begin
         random_shift_register_d = random_shift_register_step(random_shift_register_q);
         rnd_d  = ASC_RND_IDLE;
      end

      // register access
      // writes land on the request edge; read data is registered there too and is valid once waitrequest drops
      if (acc && avs_read)
      begin
         rdata_d = 32'h0;
         if (hit1)
            rdata_d[7:0] = {done_q, start_q, src_q, rnd_q, rsv_q};
         else if (hit2)
            rdata_d[7:0] = {ref_q, dec_q, lastch_q};
         else if (hitr)
            rdata_d[7:0] = res_q[11:4];
         else if (hitl)
            rdata_d[7:0] = {res_q[3:0], 4'h0};
      end
      if (acc && avs_read && hitr)
      begin
         done_d = 1'b0;
      end
      if (acc && avs_write && avs_byteenable[0] && hit1)
      begin
         // done flag is not writable
         src_d = avs_writedata[ASC_SRC_LSB +: 2];
         rnd_d = avs_writedata[ASC_RND_LSB +: 2];
         rsv_d = avs_writedata[1:0];
         if (avs_writedata[ASC_START_BIT] && st_q == ASC_IDLE &&
             avs_writedata[ASC_SRC_LSB +: 2] == ASC_SRC_SW)
         begin
            trig_d = 1'b1;
         end
      end
      if (acc && avs_write && avs_byteenable[0] && hit2)
      begin
         ref_d   = avs_writedata[ASC_REF_LSB +: 2];
         dec_d   = avs_writedata[ASC_DEC_LSB +: 2];
         endch_d = avs_writedata[ASC_CH_LSB +: 4];
      end

      case (src_q)
         ASC_SRC_PIN:   trig_d = trig_d | pin_rise;
         ASC_SRC_TIMER: trig_d = trig_d | timer_compare;
         ASC_SRC_FULL:  trig_d = 1'b1;
         default:       trig_d = trig_d;
      endcase

      case (st_q)
         ASC_IDLE:
         begin
            if (trig_d)
            begin
               st_d    = ASC_SETTLE;
               start_d = (src_d == ASC_SRC_SW);
               cnt_d   = ASC_SETTLE_CYC;
               cur_d   = (endch_d >= ASC_CH_SINGLE) ?
                         endch_d : 4'h0;
            end
         end
         ASC_SETTLE:
         begin
            if (cv.tick)
            begin
               cnt_d = cnt_q - 10'd1;
               if (cnt_q == 10'd1)
               begin
                  st_d  = ASC_CONV;
                  cnt_d = ASC_DEC_64 << dec_q;
               end
            end
         end
         ASC_CONV:
         begin
            if (cv.tick)
            begin
               cnt_d = cnt_q - 10'd1;
               if (cnt_q == 10'd1)
               begin
                  res_d    = modulator_result & res_mask(dec_q);
                  done_d   = 1'b1;
                  pulse_d  = 1'b1;
                  lastch_d = (cur_q >= ASC_CH_SINGLE) ?
                             cur_q : cur_q + 4'h1;
                  cnt_d    = ASC_SETTLE_CYC;
                  if (cur_q < ASC_CH_SINGLE && cur_q < endch_q)
                  begin
                     cur_d = cur_q + 4'h1;
                     st_d  = ASC_SETTLE;
                  end
                  else if (src_q == ASC_SRC_FULL)
                  begin
                     // back-to-back sequence, only settling between
                     cur_d = (endch_q >= ASC_CH_SINGLE) ?
                             endch_q : 4'h0;
                     st_d  = ASC_SETTLE;
                  end
                  else
                  begin
                     st_d    = ASC_IDLE;
                     start_d = 1'b0;
                  end
               end
            end
         end
         default: st_d = ASC_IDLE;
      endcase
      // registered so the pin carries no state-decode glitch
      conv_d = (st_d != ASC_IDLE);
   end
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_q <= 3'h0;  pin_lvl_q <= 1'b0;
         st_q <= ASC_IDLE;  done_q <= 1'b0;  start_q <= 1'b0;
         src_q <= ASC_SRC_SW;  rnd_q <= ASC_RND_IDLE;
         rsv_q <= ASC_RSV_RST;  ref_q <= ASC_REF_RST;
         dec_q <= ASC_DEC_RST;  endch_q <= ASC_CH_RST;
         lastch_q <= ASC_CH_RST;  cur_q <= 4'h0;  cnt_q <= 10'd0;
         res_q <= {ASC_RES_RST, 4'h0};  random_shift_register_q <= ASC_RANDOM_SHIFT_REGISTER_RST;
         wait_q <= 1'b1;  rdata_q <= 32'h0;  pulse_q <= 1'b0;
         conv_q <= 1'b0;  irq_q <= 1'b0;
      end
      else
      begin
         pin_q <= {pin_q[1:0], external_trigger_pin};
         pin_lvl_q <= pin_lvl_d;
         st_q <= st_d;  done_q <= done_d;  start_q <= start_d;
         src_q <= src_d;  rnd_q <= rnd_d;  rsv_q <= rsv_d;
         ref_q <= ref_d;  dec_q <= dec_d;  endch_q <= endch_d;
         lastch_q <= lastch_d;  cur_q <= cur_d;  cnt_q <= cnt_d;
         res_q <= res_d;  random_shift_register_q <= random_shift_register_d;
         wait_q <= wait_d;  rdata_q <= rdata_d;  pulse_q <= pulse_d;
         conv_q <= conv_d;  irq_q <= irq_d;
      end
   end

   assign avs_readdata          = rdata_q;
   assign avs_waitrequest       = wait_q;
   assign mux_channel           = cur_q;
   assign reference_select      = ref_q;
   assign converting            = conv_q;
   assign conversion_done_pulse = pulse_q;
   assign irq                   = irq_q;
endmodule : asc_ctrl

// File: verif/asc_ctrl_sva.sv
// checker: port-level timing relations of the converter control block
`timescale 1ns/10ps
module asc_ctrl_sva
   import asc_pkg::*;
(
   input wire logic        ref_clk,               // system clock
   input wire logic        rst_b,                 // async reset, active low
   input wire logic [9:0]  avs_address,           // byte address
   input wire logic        avs_read,              // read request
   input wire logic        avs_write,             // write request
   input wire logic [31:0] avs_readdata,          // read data
   input wire logic        avs_waitrequest,       // stall
   input wire logic        converting,            // sequence running
   input wire logic        conversion_done_pulse, // sample ready
   input wire logic        irq                    // interrupt
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   logic mapped;
   assign mapped = avs_address[9:2] inside
      {ASC_IDX_CTRL_ONE, ASC_IDX_CTRL_TWO, ASC_IDX_RES_LOW, ASC_IDX_RES_HIGH};
   // ----------------------------------------------------------------
   // bus answer
   // ----------------------------------------------------------------
   property p_ack_next;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("request not answered after one wait state");
   property p_ack_once;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_ack_once: assert property (p_ack_once)
      else $error("waitrequest low for more than one cycle");
   property p_upper_zero;
      !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("read data above byte zero not zero");
   property p_unmapped;
      avs_read && avs_waitrequest && !mapped |=> avs_readdata == 32'h00000000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read returned nonzero");
   // ----------------------------------------------------------------
   // conversion timing
   // ----------------------------------------------------------------
   property p_irq_low;
      irq == 1'b0;
   endproperty
   a_irq_low: assert property (p_irq_low)
      else $error("interrupt raised by sequence");
   property p_pulse_once;
      conversion_done_pulse |=> !conversion_done_pulse;
   endproperty
   a_pulse_once: assert property (p_pulse_once)
      else $error("completion pulse longer than one cycle");
   property p_pulse_in_run;
      conversion_done_pulse |-> $past(converting);
   endproperty
   a_pulse_in_run: assert property (p_pulse_in_run)
      else $error("completion without a running conversion");
   property p_settle;
      $rose(converting) |-> !conversion_done_pulse [*8];
   endproperty
   a_settle: assert property (p_settle)
      else $error("completion too soon after start");
endmodule : asc_ctrl_sva

// File: verif/asc_mod_model.sv
// partner: modulator and filter handing a fresh result per conversion
`timescale 1ns/10ps
module asc_mod_model (
   input  wire logic        ref_clk,               // system clock
   input  wire logic        conversion_done_pulse, // sample taken
   output logic      [11:0] modulator_result,      // filtered result
   output logic      [11:0] sample_q               // value the block took
);
   integer seed;
   // new value right after each sample, so a late sample sees the wrong one
   initial
   begin
      seed = 67600;
      modulator_result = 12'($random(seed));
      sample_q = 12'h000;
      forever
      begin
         @(posedge ref_clk);
         if (conversion_done_pulse === 1'b1)
         begin
            sample_q <= modulator_result;
            modulator_result <= 12'($random(seed));
         end
      end
   end
endmodule : asc_mod_model

// File: verif/asc_ctrl_bench.sv
// testbench: register access and conversion sequencing of asc_ctrl
`timescale 1ns/10ps
module asc_ctrl_bench;
   import asc_pkg::*;
   logic        ref_clk, rst_b, avs_read, avs_write, pin, tmr, wq, conv, pls;
   logic [9:0]  avs_address;
   logic [31:0] avs_writedata, rdata;
   logic [3:0]  avs_byteenable, mch;
   logic [1:0]  rsel;
   logic [11:0] mres, smp;
   int          bad_count, compares;
   logic [7:0]  c1s [4] = '{8'h73, 8'h63, 8'h03, 8'h73};
   logic [7:0]  c2s [4] = '{8'h0C, 8'hD2, 8'h6C, 8'hBF};
   int          npl [4] = '{1, 3, 1, 1};
   asc_ctrl asc_ctrl_i (.ref_clk(ref_clk), .rst_b(rst_b),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(rdata), .avs_waitrequest(wq),
      .external_trigger_pin(pin), .timer_compare(tmr),
      .modulator_result(mres), .mux_channel(mch), .reference_select(rsel),
      .converting(conv), .conversion_done_pulse(pls), .irq());
   asc_mod_model asc_mod_model_i (.ref_clk(ref_clk),
      .conversion_done_pulse(pls), .modulator_result(mres), .sample_q(smp));
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   task check(input string nm, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task summarize;
      if (bad_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize
   // ----------------------------------------------------------------
   // bus master: hold until waitrequest sampled low
   // ----------------------------------------------------------------
   task bus(input logic w, input logic [7:0] idx, wd, input logic [3:0] be,
            output logic [31:0] v);
      int n;
      avs_address <= {idx, 2'b00};
      avs_read <= ~w;
      avs_write <= w;
      avs_writedata <= {24'h000000, wd};
      avs_byteenable <= be;
      n = 0;
      do @(posedge ref_clk); while (wq !== 1'b0 && ++n < 20);
      v = rdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
      if (n >= 20)
      begin
         bad_count++;
         summarize();
      end
   endtask : bus
   task wait_pulse(output int c);
      c = 0;
      do @(posedge ref_clk); while (pls !== 1'b1 && ++c < 4000);
      if (c >= 4000)
      begin
         bad_count++;
         summarize();
      end
   endtask : wait_pulse
   // result high byte with bits below the resolution cleared
   function logic [7:0] res_hi(input logic [11:0] s, input logic [1:0] d);
      logic [11:0] m;
      m = d == 2'h0 ? 12'hFE0 : d == 2'h1 ? 12'hFF8 : d == 2'h2 ? 12'hFFC
                                                                 : 12'hFFF;
      return 8'((s & m) >> 4);
   endfunction : res_hi
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      logic [31:0] v;
      logic [7:0]  c1, c2;
      int          c, cv;
      time         t0;
      rst_b = 1'b0;
      {avs_read, avs_write, pin, tmr} = 4'h0;
      avs_address = 10'h000;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'h0;
      bad_count = 0;
      compares = 0;
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge ref_clk);
      bus(0, ASC_IDX_CTRL_ONE, 8'h00, 4'hF, v);
      check("ctrl_one", v, 32'h33);
      bus(0, ASC_IDX_CTRL_TWO, 8'h00, 4'hF, v);
      check("ctrl_two", v, 32'h10);
      bus(0, ASC_IDX_RES_HIGH, 8'h00, 4'hF, v);
      check("res_high", v, 32'h00);
      bus(0, 8'hB7, 8'h00, 4'hF, v);
      check("unmapped", v, 32'h00);
      for (int i = 0; i < 4; i++)
      begin
         c1 = c1s[i];
         c2 = c2s[i];
         cv = (16 + (64 << c2[5:4])) * 6;
         bus(1, ASC_IDX_CTRL_TWO, c2, 4'h1, v);
         bus(1, ASC_IDX_CTRL_ONE, c1, 4'h1, v);
         t0 = $time;
         repeat (8) @(posedge ref_clk);
         check("converting", conv, c1[5:4] == ASC_SRC_SW);
         if (c1[5:4] == ASC_SRC_SW)
         begin
            bus(0, ASC_IDX_CTRL_ONE, 8'h00, 4'hF, v);
            check("start_bit", v[6], 1'b1);
         end
         tmr <= 1'b1;
         pin <= 1'b1;
         @(posedge ref_clk);
         tmr <= 1'b0;
         repeat (4) @(posedge ref_clk);
         pin <= 1'b0;
         for (int k = 0; k < npl[i]; k++)
            wait_pulse(c);
         c = ($time - t0) / 50;
         if (c1[5:4] == ASC_SRC_SW)
            check("conv_time", c >= cv - 3 && c <= cv + 12, 1'b1);
         check("reference", rsel, c2[7:6]);
         if (c2[3:0] >= ASC_CH_SINGLE)
            check("channel", mch, c2[3:0]);
         repeat (20) @(posedge ref_clk);
         check("idle", conv, 1'b0);
         bus(0, ASC_IDX_CTRL_TWO, 8'h00, 4'hF, v);
         check("end_channel", v, c2[3:0] >= 4'hC ? c2 : c2 + 8'h01);
         bus(0, ASC_IDX_CTRL_ONE, 8'h00, 4'hF, v);
         check("done_set", v, {2'b10, c1[5:4], 4'h3});
         bus(0, ASC_IDX_RES_HIGH, 8'h00, 4'hF, v);
         check("res_high", v, res_hi(smp, c2[5:4]));
         bus(0, ASC_IDX_CTRL_ONE, 8'h00, 4'hF, v);
         check("done_clear", v, {2'b00, c1[5:4], 4'h3});
      end
      bus(1, ASC_IDX_CTRL_ONE, 8'h37, 4'h1, v);
      bus(0, ASC_IDX_CTRL_ONE, 8'h00, 4'hF, v);
      check("rnd_idle", v, 32'h33);
      bus(1, ASC_IDX_CTRL_TWO, 8'hFF, 4'hE, v);
      bus(0, ASC_IDX_CTRL_TWO, 8'h00, 4'hF, v);
      check("no_lane", v, 32'hBF);
      bus(1, ASC_IDX_CTRL_TWO, 8'h0C, 4'h1, v);
      bus(1, ASC_IDX_CTRL_ONE, 8'h13, 4'h1, v);
      wait_pulse(c);
      wait_pulse(c);
      check("gap", c + 1, (16 + 64) * 6);
      bus(1, ASC_IDX_CTRL_ONE, 8'h33, 4'h1, v);
      c = 0;
      while (conv !== 1'b0 && c++ < 1000)
         @(posedge ref_clk);
      check("stopped", conv, 1'b0);
      summarize();
   end
endmodule : asc_ctrl_bench
bind asc_ctrl asc_ctrl_sva asc_ctrl_sva_i (.ref_clk(ref_clk), .rst_b(rst_b),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .converting(converting), .conversion_done_pulse(conversion_done_pulse),
   .irq(irq));
